// ### design/dgc_regs.vh
`ifndef DGC_REGS_VH
`define DGC_REGS_VH

// Register byte offsets
`define DGC_OFS_GLOBAL_CTRL 8'h00
`define DGC_OFS_LAST_STATUS 8'h04
`define DGC_OFS_LAST_ADDR 8'h08
`define DGC_OFS_CRC_CTRL 8'h0C

// Global control fields
`define DGC_BIT_ENABLE 15
`define DGC_BIT_SUSPEND 12
`define DGC_BIT_ACTIVE 11

// Last access status fields
`define DGC_BIT_DIR 3
`define DGC_CHAN_HI 2
`define DGC_CHAN_LO 0

// Checksum engine control fields
`define DGC_CRC_BYTE_ORDER_HI 29
`define DGC_CRC_BYTE_ORDER_LO 28
`define DGC_BIT_WBO 27
`define DGC_BIT_CRC_BIT_ORDER 24
`define DGC_POLYNOMIAL_LENGTH_HI 12
`define DGC_POLYNOMIAL_LENGTH_LO 8
`define DGC_BIT_ROUTE 7
`define DGC_BIT_APPEND 6
`define DGC_BIT_TYPE 5
`define DGC_CCH_HI 2
`define DGC_CCH_LO 0

// Byte order encodings
`define DGC_CRC_BYTE_ORDER_NONE 2'h0
`define DGC_CRC_BYTE_ORDER_WORD 2'h1
`define DGC_CRC_BYTE_ORDER_HALF 2'h2
`define DGC_CRC_BYTE_ORDER_HSWAP 2'h3

// Reset values
`define DGC_RST_WORD 32'h0000_0000
`define DGC_RST_CHAN 3'h0
`define DGC_RST_CRC_BYTE_ORDER 2'h0
`define DGC_RST_POLYNOMIAL_LENGTH 5'h00

`endif

// ### design/dgc_byte_order.v
`default_nettype none

module dgc_byte_order (
  // Selection
  input wire [1:0] i_mode,
  input wire i_wbo,
  // Data
  input wire [31:0] i_data,
  output wire [31:0] o_crc_word,
  output wire [31:0] o_dst_word
);

`include "dgc_regs.vh"

  ////////////////////////////////////////////////////////////////////////////
  // Reorder one word by the selected byte order
  function [31:0] dgc_reorder;
    input [1:0] mode;
    input [31:0] d;
    begin
      case (mode)
        `DGC_CRC_BYTE_ORDER_HSWAP: dgc_reorder = {d[23:16], d[31:24], d[7:0], d[15:8]}; // R8
        `DGC_CRC_BYTE_ORDER_HALF: dgc_reorder = {d[15:0], d[31:16]}; // R8
        `DGC_CRC_BYTE_ORDER_WORD: dgc_reorder = {d[7:0], d[15:8], d[23:16], d[31:24]}; // R9
        default: dgc_reorder = d; // R9
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Checksum feed always reordered, destination only when enabled
  assign o_crc_word = dgc_reorder(i_mode, i_data);
  assign o_dst_word = i_wbo ? dgc_reorder(i_mode, i_data) : i_data; // R10

endmodule // dgc_byte_order

`default_nettype wire

// ### design/dgc_skid_buf.v
`default_nettype none

module dgc_skid_buf #(
  parameter W = 64
) (
  // Clock and reset
  input wire i_clk,
  input wire i_nrst,
  // Pause both sides
  input wire i_hold,
  // Filling side
  input wire i_valid,
  input wire [W-1:0] i_data,
  output wire o_ready,
  // Draining side
  output wire o_valid,
  output wire [W-1:0] o_data,
  input wire i_ready
);

  reg [W-1:0] head_ff;
  reg [W-1:0] spare_ff;
  reg [1:0] cnt_ff;
  reg valid_ff;
  reg ready_ff;
  reg [1:0] nxt_cnt;
  wire push;
  wire pop;

  assign push = i_valid & ready_ff;
  assign pop = valid_ff & i_ready;
  assign o_ready = ready_ff;
  assign o_valid = valid_ff;
  assign o_data = head_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Fill level
  always @* begin
    nxt_cnt = cnt_ff;
    if (push && !pop) begin
      nxt_cnt = cnt_ff + 2'h1;
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Head always holds the oldest word so the output is a plain flop
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      head_ff <= {W{1'b0}};
      spare_ff <= {W{1'b0}};
      cnt_ff <= 2'h0;
      valid_ff <= 1'b0;
      ready_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      // Handshakes are registered, so a hold takes one cycle to bite
      valid_ff <= (nxt_cnt != 2'h0) && !i_hold;
      ready_ff <= (nxt_cnt != 2'h2) && !i_hold;
      if (pop) begin
        if (cnt_ff == 2'h2) begin
          head_ff <= spare_ff;
          if (push) begin
            spare_ff <= i_data;
          end
        end else if (push) begin
          head_ff <= i_data;
        end
      end else if (push) begin
        if (cnt_ff == 2'h0) begin
          head_ff <= i_data;
        end else begin
          spare_ff <= i_data;
        end
      end
    end
  end

endmodule // dgc_skid_buf

`default_nettype wire

// ### design/dgc_top.v
// Functional notes
// R1: Enable bit runs controller; clear disables all
// R2: Suspend stops transfers, yields bus to processor
// R3: Busy reads one while module is active
// R4: Software skips access right after disabling
// R5: Direction bit one means last access read
// R6: Channel field holds last active channel
// R7: Address register holds last access address
// R8: Modes 11 and 10 swap bytes, halves
// R9: Mode 01 reverses word; 00 passes through
// R10: Write reorder bit applies order to destination
// R11: Bit order bit reflects IP checksum
// R12: Unimplemented bits ignore writes, read zero
// R13: Type bit selects IP checksum or shift register
// R14: Bit order bit reflects shift register CRC
// R15: Append mode never set with write reorder
// R16: Direction, channel, address update together
//
// Chosen here: the register offsets and the plain strobed port.
`default_nettype none

module dgc_top (
  // Clock and reset
  input wire i_clk,
  input wire i_nrst,
  // Register port
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output wire [31:0] o_rdata,
  // Bus access reports from the channels
  input wire i_acc_valid,
  input wire i_acc_read,
  input wire [2:0] i_acc_chan,
  input wire [31:0] i_acc_addr,
  input wire i_xfer_active,
  // Transfer permission to the channels
  output wire o_xfer_allow,
  output wire o_module_active,
  // Source data stream
  input wire i_src_valid,
  input wire [31:0] i_src_data,
  output wire o_src_ready,
  // Reordered words toward checksum engine and destination
  output wire o_out_valid,
  output wire [31:0] o_crc_data,
  output wire [31:0] o_dst_data,
  input wire i_out_ready,
  // Checksum engine configuration
  output wire o_crc_route_en,
  output wire o_crc_append,
  output wire o_crc_ip_mode,
  output wire o_crc_reflect,
  output wire [4:0] o_crc_polynomial_length,
  output wire [2:0] o_crc_chan
);

`include "dgc_regs.vh"

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  reg enable_ff;
  reg suspend_ff;
  reg active_ff;
  reg run_ff;
  reg dir_ff;
  reg [2:0] chan_ff;
  reg [31:0] acc_addr_ff;
  reg [1:0] crc_byte_order_ff;
  reg wbo_ff;
  reg crc_bit_order_ff;
  reg [4:0] polynomial_length_ff;
  reg route_ff;
  reg append_ff;
  reg type_ff;
  reg [2:0] cch_ff;
  reg [31:0] rdata_ff;
  reg [31:0] nxt_rdata;
  wire wr_ctrl;
  wire wr_crc;
  wire nxt_wbo;
  wire buf_busy;
  wire [31:0] crc_word;
  wire [31:0] dst_word;
  wire [63:0] buf_out;

  ////////////////////////////////////////////////////////////////////////////
  // Write decode
  assign wr_ctrl = i_wr && (i_addr == `DGC_OFS_GLOBAL_CTRL);
  assign wr_crc = i_wr && (i_addr == `DGC_OFS_CRC_CTRL);
  assign nxt_wbo = i_wdata[`DGC_BIT_WBO];

  ////////////////////////////////////////////////////////////////////////////
  // Global control; only the writable bits are kept
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      enable_ff <= 1'b0;
      suspend_ff <= 1'b0;
    end else if (wr_ctrl) begin
      enable_ff <= i_wdata[`DGC_BIT_ENABLE]; // R1
      suspend_ff <= i_wdata[`DGC_BIT_SUSPEND]; // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transfer permission and activity, one cycle behind the bits
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      run_ff <= 1'b0;
      active_ff <= 1'b0;
    end else begin
      run_ff <= enable_ff && !suspend_ff; // R1 R2
      // Stays high while a channel still reports activity after a disable; words held in the buffer do not count
      active_ff <= enable_ff || i_xfer_active || buf_busy; // R3
    end
  end

  assign o_xfer_allow = run_ff;
  assign o_module_active = active_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Last access record; all three fields load in the same edge
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      dir_ff <= 1'b0;
      chan_ff <= `DGC_RST_CHAN;
      acc_addr_ff <= `DGC_RST_WORD; // R7
    end else if (i_acc_valid) begin // R16
      dir_ff <= i_acc_read; // R5
      chan_ff <= i_acc_chan; // R6
      acc_addr_ff <= i_acc_addr; // R7
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checksum engine control
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      crc_byte_order_ff <= `DGC_RST_CRC_BYTE_ORDER;
      wbo_ff <= 1'b0;
      crc_bit_order_ff <= 1'b0;
      polynomial_length_ff <= `DGC_RST_POLYNOMIAL_LENGTH;
      route_ff <= 1'b0;
      append_ff <= 1'b0;
      type_ff <= 1'b0;
      cch_ff <= `DGC_RST_CHAN;
    end else if (wr_crc) begin
      crc_byte_order_ff <= i_wdata[`DGC_CRC_BYTE_ORDER_HI:`DGC_CRC_BYTE_ORDER_LO]; // R8 R9
      wbo_ff <= nxt_wbo; // R10
      crc_bit_order_ff <= i_wdata[`DGC_BIT_CRC_BIT_ORDER]; // R11 R14
      polynomial_length_ff <= i_wdata[`DGC_POLYNOMIAL_LENGTH_HI:`DGC_POLYNOMIAL_LENGTH_LO];
      route_ff <= i_wdata[`DGC_BIT_ROUTE];
      // Append refused whenever write reordering is on
      append_ff <= i_wdata[`DGC_BIT_APPEND] && !nxt_wbo; // R15
      type_ff <= i_wdata[`DGC_BIT_TYPE]; // R13
      cch_ff <= i_wdata[`DGC_CCH_HI:`DGC_CCH_LO];
    end
  end

  assign o_crc_route_en = route_ff;
  assign o_crc_append = append_ff;
  assign o_crc_ip_mode = type_ff; // R13
  assign o_crc_reflect = crc_bit_order_ff; // R11 R14
  assign o_crc_polynomial_length = polynomial_length_ff;
  assign o_crc_chan = cch_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Read mux; unlisted bits stay zero
  always @* begin
    nxt_rdata = `DGC_RST_WORD; // R12
    if (i_rd) begin
      case (i_addr)
        `DGC_OFS_GLOBAL_CTRL: begin
          nxt_rdata[`DGC_BIT_ENABLE] = enable_ff;
          nxt_rdata[`DGC_BIT_SUSPEND] = suspend_ff;
          nxt_rdata[`DGC_BIT_ACTIVE] = active_ff; // R3
        end
        `DGC_OFS_LAST_STATUS: begin
          nxt_rdata[`DGC_BIT_DIR] = dir_ff; // R5
          nxt_rdata[`DGC_CHAN_HI:`DGC_CHAN_LO] = chan_ff; // R6
        end
        `DGC_OFS_LAST_ADDR: begin
          nxt_rdata = acc_addr_ff; // R7
        end
        `DGC_OFS_CRC_CTRL: begin
          nxt_rdata[`DGC_CRC_BYTE_ORDER_HI:`DGC_CRC_BYTE_ORDER_LO] = crc_byte_order_ff;
          nxt_rdata[`DGC_BIT_WBO] = wbo_ff;
          nxt_rdata[`DGC_BIT_CRC_BIT_ORDER] = crc_bit_order_ff;
          nxt_rdata[`DGC_POLYNOMIAL_LENGTH_HI:`DGC_POLYNOMIAL_LENGTH_LO] = polynomial_length_ff;
          nxt_rdata[`DGC_BIT_ROUTE] = route_ff;
          nxt_rdata[`DGC_BIT_APPEND] = append_ff;
          nxt_rdata[`DGC_BIT_TYPE] = type_ff;
          nxt_rdata[`DGC_CCH_HI:`DGC_CCH_LO] = cch_ff;
        end
        default: begin
          nxt_rdata = `DGC_RST_WORD; // R12
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data valid only in the cycle after the strobe
  always @(posedge i_clk) begin
    if (!i_nrst) begin
      rdata_ff <= `DGC_RST_WORD;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////
  // Reorder before buffering so the outputs leave from flops
  dgc_byte_order u_order (
    .i_mode(crc_byte_order_ff),
    .i_wbo(wbo_ff),
    .i_data(i_src_data),
    .o_crc_word(crc_word),
    .o_dst_word(dst_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Two-entry buffer; held while disabled or suspended
  dgc_skid_buf #(
    .W(64)
  ) u_buf (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_hold(!run_ff), // R1 R2
    .i_valid(i_src_valid),
    .i_data({crc_word, dst_word}),
    .o_ready(o_src_ready),
    .o_valid(o_out_valid),
    .o_data(buf_out),
    .i_ready(i_out_ready)
  );

  // Buffered words count as activity only while the buffer runs; held words do not
  assign buf_busy = o_out_valid || !o_src_ready && run_ff;
  assign o_crc_data = buf_out[63:32];
  assign o_dst_data = buf_out[31:0];

endmodule // dgc_top

`default_nettype wire

// ### tb/dgc_chk.sv
`default_nettype none
module dgc_chk (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Register port
  input wire logic [7:0] i_addr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  // Access reports and activity
  input wire logic i_acc_valid,
  input wire logic i_acc_read,
  input wire logic [2:0] i_acc_chan,
  input wire logic [31:0] i_acc_addr,
  input wire logic i_xfer_active,
  input wire logic o_module_active,
  // Transfer gate and stream
  input wire logic o_xfer_allow,
  input wire logic o_src_ready,
  input wire logic o_out_valid,
  input wire logic [31:0] o_crc_data,
  input wire logic i_out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  ////////////////////////////////////////
  // Report, then a read of one status place with no newer report
  sequence acc_rd(logic [7:0] a);
    i_acc_valid ##1 (i_rd && i_addr == a && !i_acc_valid);
  endsequence
  rd_idle_a: assert property (!i_rd |=> o_rdata == 32'h0)
    else $error("read data not idle");
  acc_addr_a: assert property (acc_rd(8'h08) |=> o_rdata == $past(i_acc_addr, 2))
    else $error("address not tracked");
  acc_stat_a: assert property (acc_rd(8'h04) |=>
    o_rdata == {28'h0, $past(i_acc_read, 2), $past(i_acc_chan, 2)}) else $error("bad status");
  ctrl_zero_a: assert property (i_rd && i_addr == 8'h00 |=>
    (o_rdata & 32'hFFFF67FF) == 32'h0) else $error("control bits");
  crc_zero_a: assert property (i_rd && i_addr == 8'h0C |=>
    (o_rdata & 32'hC6FFE018) == 32'h0 && !(o_rdata[27] && o_rdata[6])) else $error("crc bits");
  busy_xfer_a: assert property (i_xfer_active |=> o_module_active)
    else $error("busy low");
  // A hold may drop valid with no ready; only a running buffer must keep its word up
  out_hold_a: assert property (o_out_valid && !i_out_ready && o_xfer_allow |=>
    o_out_valid && $stable(o_crc_data)) else $error("word dropped");
  gate_off_a: assert property (!o_xfer_allow [*2] |-> !o_src_ready && !o_out_valid)
    else $error("stream ran while held");
endmodule // dgc_chk

bind dgc_top dgc_chk u_chk (.i_clk, .i_nrst, .i_addr, .i_rd, .o_rdata, .i_acc_valid,
  .i_acc_read, .i_acc_chan, .i_acc_addr, .i_xfer_active, .o_module_active, .o_xfer_allow,
  .o_src_ready, .o_out_valid, .o_crc_data, .i_out_ready);
`default_nettype wire

// ### tb/dgc_sink.sv
`default_nettype none
module dgc_sink (
  // Clock
  input wire logic i_clk,
  // Slow mode request
  input wire logic i_slow,
  // Handshake toward the block
  output logic o_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_ff = 2'h0;
  initial o_ready = 1'b0;
  // Slow mode takes one word in four, so the buffer fills
  always @(posedge i_clk) begin
    cnt_ff <= cnt_ff + 2'h1;
    o_ready <= !i_slow || cnt_ff == 2'h3;
  end
endmodule // dgc_sink
`default_nettype wire

// ### tb/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_acc_valid = 1'b0;
  logic i_acc_read = 1'b0;
  logic [2:0] i_acc_chan = 3'h0;
  logic i_xfer_active = 1'b0;
  logic i_src_valid = 1'b0;
  logic i_out_ready, slow = 1'b0, rd_pend = 1'b0, write_reorder_enable = 1'b0;
  logic [31:0] i_wdata = 32'h0, i_acc_addr = 32'h0, i_src_data = 32'h0, rng = 32'hA957;
  logic o_xfer_allow, o_module_active, o_src_ready, o_out_valid;
  logic o_crc_route_en, o_crc_append, o_crc_ip_mode, o_crc_reflect;
  logic [31:0] o_rdata, o_crc_data, o_dst_data;
  logic [4:0] o_crc_polynomial_length;
  logic [2:0] o_crc_chan;
  logic [1:0] crc_byte_order = 2'h0;
  logic [31:0] rq[$], cq[$], dq[$];
  int miscompares = 0;
  int compares = 0;

  always #10 i_clk = ~i_clk;

  dgc_top uut (.i_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_acc_valid,
    .i_acc_read, .i_acc_chan, .i_acc_addr, .i_xfer_active, .o_xfer_allow, .o_module_active,
    .i_src_valid, .i_src_data, .o_src_ready, .o_out_valid, .o_crc_data, .o_dst_data,
    .i_out_ready, .o_crc_route_en, .o_crc_append, .o_crc_ip_mode, .o_crc_reflect,
    .o_crc_polynomial_length, .o_crc_chan);
  dgc_sink u_sink (.i_clk, .i_slow(slow), .o_ready(i_out_ready));

  ////////////////////////////////////////
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // Expected reordering of one source word
  function automatic logic [31:0] ro(input logic [1:0] m, input logic [31:0] w);
    case (m)
      2'h1: return {w[7:0], w[15:8], w[23:16], w[31:24]};
      2'h2: return {w[15:0], w[31:16]};
      2'h3: return {w[23:16], w[31:24], w[7:0], w[15:8]};
      default: return w;
    endcase
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  // Strobes stay as set until the next call, so no signal is driven twice per step
  task automatic bus(input logic w, input logic r, input logic [7:0] a, input logic [31:0] v);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= v;
    @(posedge i_clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    rq.push_back(e);
    bus(1'b0, 1'b1, a, 32'h0);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 32'h0);
  endtask
  // Checksum configuration outputs, sampled mid-cycle while the bus is idle
  task automatic cfg(input logic [11:0] e);
    @(negedge i_clk);
    chk({o_crc_route_en, o_crc_append, o_crc_ip_mode, o_crc_reflect, o_crc_polynomial_length, o_crc_chan}, e);
    @(posedge i_clk);
  endtask
  // Held until the edge that sees ready high
  task automatic send(input logic [31:0] w);
    logic r;
    cq.push_back(ro(crc_byte_order, w));
    dq.push_back(write_reorder_enable ? ro(crc_byte_order, w) : w);
    i_src_valid <= 1'b1;
    i_src_data <= w;
    r = 1'b0;
    while (!r) begin
      @(negedge i_clk);
      r = o_src_ready;
      @(posedge i_clk);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Monitor: read data stands only in the cycle after the strobe
  always @(negedge i_clk) begin
    if (rd_pend) chk(o_rdata, rq.pop_front());
    rd_pend = i_rd;
    if (o_out_valid && i_out_ready) begin
      chk(o_crc_data, cq.pop_front());
      chk(o_dst_data, dq.pop_front());
    end
  end

  // Run is under 700 cycles; far beyond that means a hang
  initial begin
    #100000;
    miscompares++;
    complete_run();
  end

  initial begin
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    idle(1);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    rd(8'h0C, 32'h0);
    rd(8'h10, 32'h0);
    // All bits set: append is refused beside write reorder
    bus(1'b1, 1'b0, 8'h00, 32'hFFFFFFFF);
    bus(1'b1, 1'b0, 8'h0C, 32'hFFFFFFFF);
    idle(2);
    rd(8'h00, 32'h00009800);
    rd(8'h0C, 32'h39001FA7);
    idle(1);
    cfg({4'hB, 5'h1F, 3'h7});
    bus(1'b1, 1'b0, 8'h0C, 32'h00000043);
    rd(8'h0C, 32'h00000043);
    idle(1);
    cfg({4'h4, 5'h00, 3'h3});
    bus(1'b1, 1'b0, 8'h00, 32'h00008000);
    // Every byte order with and without write reorder
    for (int m = 0; m < 8; m++) begin
      crc_byte_order = m[2:1];
      write_reorder_enable = m[0];
      slow <= m[1];
      bus(1'b1, 1'b0, 8'h0C, {2'h0, crc_byte_order, write_reorder_enable, 27'h0});
      idle(2);
      repeat (3) begin
        rng = xs(rng);
        send(rng);
      end
      i_src_valid <= 1'b0;
      idle(1);
    end
    // Suspend with words still buffered; they must survive
    bus(1'b1, 1'b0, 8'h00, 32'h00009000);
    idle(3);
    @(negedge i_clk);
    chk({o_xfer_allow, o_src_ready, o_out_valid}, 32'h0);
    @(posedge i_clk);
    bus(1'b1, 1'b0, 8'h00, 32'h00008000);
    for (int k = 0; k < 60 && cq.size() > 0; k++) idle(1);
    chk(cq.size(), 32'h0);
    // Access reports, status read in both orders
    for (int k = 0; k < 4; k++) begin
      rng = xs(rng);
      i_acc_valid <= 1'b1;
      i_acc_read <= rng[3];
      i_acc_chan <= rng[2:0];
      i_acc_addr <= rng;
      // Idle strobes here, or the last read of the previous pass would repeat
      idle(1);
      i_acc_valid <= 1'b0;
      rd(k[0] ? 8'h04 : 8'h08, k[0] ? {28'h0, rng[3:0]} : rng);
      rd(k[0] ? 8'h08 : 8'h04, k[0] ? rng : {28'h0, rng[3:0]});
    end
    // Disable while a channel still moves data
    i_xfer_active <= 1'b1;
    bus(1'b1, 1'b0, 8'h00, 32'h0);
    idle(1);
    rd(8'h00, 32'h00000800);
    i_xfer_active <= 1'b0;
    idle(2);
    rd(8'h00, 32'h0);
    idle(1);
    complete_run();
  end
endmodule // tb_top
`default_nettype wire
